// ===== hw/cpu_exec_pkg.sv
// constants, types and decode helpers for the add/cycle execution block
package cpu_exec_pkg;

   // ==========================================================
   // timing
   localparam int Q_PER_CYCLE = 4;
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;
   localparam logic [1:0] CYC_THREE = 2'h3;

   // ==========================================================
   // register map, byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_INSTR = 8'h04;
   localparam logic [7:0] OFS_WORK = 8'h08;
   localparam logic [7:0] OFS_FILE = 8'h0C;
   localparam logic [7:0] OFS_FLAGS = 8'h10;
   localparam logic [7:0] OFS_PC = 8'h14;
   localparam logic [7:0] OFS_PC_LATCH = 8'h18;
   localparam logic [7:0] OFS_STAT = 8'h1C;

   // ==========================================================
   // field positions and reset values
   localparam int FLAG_C = 0;
   localparam int FLAG_DIGIT = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_OVERFLOW = 3;
   localparam int CTRL_FULL = 0;
   localparam int CTRL_TBL_INT = 1;
   localparam logic [1:0] CTRL_RST = 2'h1;
   localparam logic [15:0] PC_RST = 16'h0000;
   localparam logic [7:0] PC_LOW_FILE_ADDR = 8'h02;

   // ==========================================================
   // opcode fields
   localparam logic [7:0] OP_ADD_LIT = 8'hB1;
   localparam logic [7:0] OP_LONG_CALL = 8'hB7;
   localparam logic [7:0] OP_RETLW = 8'hB6;
   localparam logic [7:0] OP_MULLW = 8'hBC;
   localparam logic [7:0] OP_MULWF = 8'h34;
   localparam logic [7:0] OP_TSTFSZ = 8'h33;
   localparam logic [6:0] OP_MOVLR = 7'h5D;
   localparam logic [6:0] OP_ADD_FILE = 7'h07;
   localparam logic [6:0] OP_ADD_CARRY = 7'h08;
   localparam logic [6:0] OP_SETF = 7'h15;
   localparam logic [6:0] OP_NEGW = 7'h16;
   localparam logic [5:0] OP_TBL_READ = 6'h2A;
   localparam logic [5:0] OP_TABLWT = 6'h2B;
   localparam logic [4:0] OP_BTFSC = 5'h13;
   localparam logic [4:0] OP_BTFSS = 5'h12;
   localparam logic [2:0] OP_GOTO = 3'h6;
   localparam logic [2:0] OP_CALL = 3'h7;
   localparam logic [15:0] INS_RETURN = 16'h0002;
   localparam logic [15:0] INS_RETFIE = 16'h0005;

   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} exec_fsm_t;

   typedef enum logic [3:0] {
      OPC_OTHER, OPC_ADD_LIT, OPC_ADD_FILE, OPC_ADD_CARRY, OPC_NEGW, OPC_SETF, OPC_LONG_CALL,
      OPC_JUMP, OPC_BRANCH, OPC_TBL_READ, OPC_TABLWT, OPC_SKIP, OPC_FULLONLY
   } op_class_t;

   function automatic op_class_t op_decode(input logic [15:0] ins);
      op_decode = OPC_OTHER;
      if (ins[15:8] == OP_ADD_LIT) op_decode = OPC_ADD_LIT;
      else if (ins[15:8] == OP_LONG_CALL) op_decode = OPC_LONG_CALL;
      else if (ins[15:8] == OP_RETLW || ins == INS_RETURN || ins == INS_RETFIE) begin
         op_decode = OPC_BRANCH;
      end else if (ins[15:8] == OP_TSTFSZ || ins[15:11] == OP_BTFSC ||
                   ins[15:11] == OP_BTFSS) begin
         op_decode = OPC_SKIP;
      end else if (ins[15:8] == OP_MULWF || ins[15:8] == OP_MULLW ||
                   ins[15:9] == OP_MOVLR) begin
         op_decode = OPC_FULLONLY;
      end else if (ins[15:9] == OP_ADD_FILE) op_decode = OPC_ADD_FILE;
      else if (ins[15:9] == OP_ADD_CARRY) op_decode = OPC_ADD_CARRY;
      else if (ins[15:9] == OP_NEGW) op_decode = OPC_NEGW;
      else if (ins[15:9] == OP_SETF) op_decode = OPC_SETF;
      else if (ins[15:10] == OP_TBL_READ) op_decode = OPC_TBL_READ;
      else if (ins[15:10] == OP_TABLWT) op_decode = OPC_TABLWT;
      else if (ins[15:13] == OP_GOTO || ins[15:13] == OP_CALL) op_decode = OPC_JUMP;
   endfunction : op_decode

endpackage : cpu_exec_pkg

// ===== hw/cpu_exec_if.sv
// interfaces between the execution top and its adder and cycle timer
`timescale 1ns/100ps

// ==========================================================
interface add_flag_if;
   logic [7:0] a;
   logic [7:0] b;
   logic cin;
   logic [7:0] sum;
   logic c;
   logic dig;
   logic z;
   logic ovf;
   modport user (output a, b, cin, input sum, c, dig, z, ovf);
   modport unit (input a, b, cin, output sum, c, dig, z, ovf);
endinterface : add_flag_if

// ==========================================================
interface cycle_timer_if;
   logic start;
   logic [1:0] ncycles;
   logic endless;
   logic stop;
   logic busy;
   logic done;
   modport ctl (output start, ncycles, endless, stop, input busy, done);
   modport timer (input start, ncycles, endless, stop, output busy, done);
endinterface : cycle_timer_if

// ===== hw/add_flag_unit.sv
// 8-bit adder with carry, digit carry, zero and overflow flags
`timescale 1ns/100ps
module add_flag_unit
   import cpu_exec_pkg::*;
(
   add_flag_if.unit af
);
   logic [8:0] full_sum;
   logic [4:0] low_sum;

   // ==========================================================
   // arithmetic
   always_comb begin
      full_sum = {1'b0, af.a} + {1'b0, af.b} + {8'h00, af.cin};
      low_sum = {1'b0, af.a[3:0]} + {1'b0, af.b[3:0]} + {4'h0, af.cin};
      af.sum = full_sum[7:0];
      af.c = full_sum[8];
      af.dig = low_sum[4];
      af.z = (full_sum[7:0] == 8'h00);
      // signed overflow: like signs in, other sign out [RULE1]
      af.ovf = (af.a[7] == af.b[7]) && (full_sum[7] != af.a[7]);
   end

endmodule : add_flag_unit

// ===== hw/instr_cycle_timer.sv
// counts instruction cycles of four clocks each for one executing instruction
`timescale 1ns/100ps
module instr_cycle_timer
   import cpu_exec_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   cycle_timer_if.timer tm
);
   typedef struct packed {
      logic run;
      logic [1:0] div;
      logic [1:0] left;
      logic endless;
      logic stop_seen;
   } timer_state_t;

   timer_state_t s;
   timer_state_t next_s;
   logic last_q;

   // ==========================================================
   // sequencing
   always_comb begin
      next_s = s;
      tm.done = 1'b0;
      last_q = (s.div == 2'(Q_PER_CYCLE - 1));
      if (!s.run) begin
         if (tm.start) begin
            next_s.run = 1'b1;
            next_s.div = 2'h0;
            next_s.left = tm.ncycles;
            next_s.endless = tm.endless;
            next_s.stop_seen = 1'b0;
         end
      end else begin
         if (tm.stop) next_s.stop_seen = 1'b1;
         if (last_q) begin
            next_s.div = 2'h0;
            // endless runs end only at a cycle boundary after a stop [RULE4]
            if (s.endless ? (s.stop_seen || tm.stop) : (s.left == CYC_ONE)) begin
               tm.done = 1'b1;
               next_s.run = 1'b0;
            end else if (!s.endless) begin
               next_s.left = s.left - CYC_ONE;
            end
         end else begin
            next_s.div = s.div + 2'h1;
         end
      end
   end

   assign tm.busy = s.run;

   always_ff @(posedge core_clk) begin
      if (sys_rst) s <= '0;
      else s <= next_s;
   end

endmodule : instr_cycle_timer

// ===== hw/cpu_exec_top.sv
// execution unit for add instructions, long call and cycle/skip timing
//
// Summary of operation
// [RULE1] add results and overflow use two's complement
// [RULE2] s=1 writes file only, s=0 both
// [RULE3] long call loads pc from latch and literal
// [RULE4] internal table write runs until interrupt event
// [RULE5] external table write takes exactly two cycles
// [RULE6] conditional skip: two cycles if true, else one
// [RULE7] branches two cycles, low-byte table read three
// [RULE8] taken skip replaces fetched instruction with no-operation
// [RULE9] multiply and bank high load need full variant
// [RULE10] add w to file, d picks destination, flags
// [RULE11] add literal to w, updates four flags
// [RULE12] add w, file and carry to destination
`timescale 1ns/100ps
module cpu_exec_top
   import cpu_exec_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic interrupt_event,
   output logic exec_busy
);
   typedef struct packed {
      exec_fsm_t st;
      logic [15:0] instr;
      logic [7:0] working_register;
      logic [7:0] file_data;
      logic [3:0] flags;
      logic [15:0] pc;
      logic [7:0] pc_high_latch;
      logic [1:0] ctrl;
      logic illegal;
      logic skipped;
      logic evt_seen;
      logic [7:0] cyc_cnt;
      logic [31:0] prdata;
   } exec_state_t;

   exec_state_t s;
   exec_state_t next_s;
   op_class_t cls;
   logic access;
   logic write_ok;
   logic mapped;
   logic start;
   logic skip_now;
   logic file_only;

   add_flag_if af ();
   cycle_timer_if tm ();

   add_flag_unit u_add (.af(af));
   instr_cycle_timer u_timer (.core_clk(core_clk), .sys_rst(sys_rst), .tm(tm));

   // ==========================================================
   // decode helpers
   function automatic logic skip_true(input logic [15:0] ins, input logic [7:0] f);
      if (ins[15:8] == OP_TSTFSZ) skip_true = (f == 8'h00);
      else if (ins[15:11] == OP_BTFSC) skip_true = !f[ins[10:8]];
      else skip_true = f[ins[10:8]];
   endfunction : skip_true

   function automatic logic [1:0] cycles_of(input op_class_t c, input logic [15:0] ins,
                                            input logic [7:0] f);
      case (c)
         OPC_SKIP: cycles_of = skip_true(ins, f) ? CYC_TWO : CYC_ONE; // [RULE6]
         OPC_JUMP, OPC_LONG_CALL, OPC_BRANCH: cycles_of = CYC_TWO; // [RULE7]
         OPC_TABLWT: cycles_of = CYC_TWO; // [RULE5]
         OPC_TBL_READ: cycles_of = (ins[7:0] == PC_LOW_FILE_ADDR) ? CYC_THREE : CYC_TWO; // [RULE7]
         default: cycles_of = CYC_ONE; // [RULE10] [RULE11] [RULE12]
      endcase
   endfunction : cycles_of

   // ==========================================================
   // bus decode; the slave never waits, so busy refusals show as pslverr
   always_comb begin
      access = psel && penable;
      mapped = (paddr <= OFS_STAT) && (paddr[1:0] == 2'h0);
      write_ok = access && pwrite && mapped && (s.st == ST_IDLE);
      start = write_ok && (paddr == OFS_INSTR);
      pready = 1'b1;
      pslverr = access && (!mapped || (pwrite && s.st != ST_IDLE && paddr != OFS_STAT));
      cls = op_decode(s.instr);
      skip_now = skip_true(s.instr, s.file_data);
      file_only = s.instr[8];
   end

   // ==========================================================
   // adder operand selection
   always_comb begin
      af.a = s.working_register;
      af.b = s.file_data;
      af.cin = 1'b0;
      case (cls)
         OPC_ADD_LIT: af.b = s.instr[7:0];
         OPC_ADD_CARRY: af.cin = s.flags[FLAG_C];
         OPC_NEGW: begin
            // negation as inverted w plus one
            af.a = ~s.working_register;
            af.b = 8'h00;
            af.cin = 1'b1;
         end
         default: af.cin = 1'b0;
      endcase
   end

   assign tm.start = start;
   assign tm.ncycles = cycles_of(op_decode(pwdata[15:0]), pwdata[15:0], s.file_data);
   assign tm.endless = (op_decode(pwdata[15:0]) == OPC_TABLWT) && s.ctrl[CTRL_TBL_INT]; // [RULE4]
   assign tm.stop = interrupt_event;

   // ==========================================================
   // registers and execution
   always_comb begin
      next_s = s;
      if (psel && !penable) begin
         case (paddr)
            OFS_CTRL: next_s.prdata = {30'h0000_0000, s.ctrl};
            OFS_INSTR: next_s.prdata = {16'h0000, s.instr};
            OFS_WORK: next_s.prdata = {24'h00_0000, s.working_register};
            OFS_FILE: next_s.prdata = {24'h00_0000, s.file_data};
            OFS_FLAGS: next_s.prdata = {28'h000_0000, s.flags};
            OFS_PC: next_s.prdata = {16'h0000, s.pc};
            OFS_PC_LATCH: next_s.prdata = {24'h00_0000, s.pc_high_latch};
            OFS_STAT: next_s.prdata = {28'h000_0000, s.evt_seen, s.illegal, s.skipped,
                                       exec_busy};
            default: next_s.prdata = 32'h0000_0000;
         endcase
      end
      if (write_ok) begin
         case (paddr)
            OFS_CTRL: next_s.ctrl = pwdata[1:0];
            OFS_INSTR: next_s.instr = pwdata[15:0];
            OFS_WORK: next_s.working_register = pwdata[7:0];
            OFS_FILE: next_s.file_data = pwdata[7:0];
            OFS_FLAGS: next_s.flags = pwdata[3:0];
            OFS_PC: next_s.pc = pwdata[15:0];
            OFS_PC_LATCH: next_s.pc_high_latch = pwdata[7:0];
            default: next_s.ctrl = s.ctrl;
         endcase
      end
      case (s.st)
         ST_IDLE: begin
            if (start) begin
               next_s.st = ST_EXEC;
               next_s.illegal = 1'b0;
               next_s.skipped = 1'b0;
               next_s.evt_seen = 1'b0;
               next_s.cyc_cnt = 8'h00;
            end
         end
         ST_EXEC: begin
            next_s.cyc_cnt = s.cyc_cnt + 8'h01;
            if (interrupt_event) next_s.evt_seen = 1'b1;
            if (tm.done) begin
               next_s.st = ST_IDLE;
               next_s.pc = s.pc + 16'h0001;
               case (cls)
                  OPC_ADD_LIT: begin
                     next_s.working_register = af.sum; // [RULE11]
                     next_s.flags = {af.ovf, af.z, af.dig, af.c}; // [RULE1]
                  end
                  OPC_ADD_FILE, OPC_ADD_CARRY: begin
                     // d=1 to file, d=0 to w [RULE10] [RULE12]
                     if (s.instr[8]) next_s.file_data = af.sum;
                     else next_s.working_register = af.sum;
                     next_s.flags = {af.ovf, af.z, af.dig, af.c};
                  end
                  OPC_NEGW: begin
                     next_s.file_data = af.sum;
                     if (!file_only) next_s.working_register = af.sum; // [RULE2]
                     next_s.flags = {af.ovf, af.z, af.dig, af.c};
                  end
                  OPC_SETF: begin
                     next_s.file_data = 8'hFF;
                     if (!file_only) next_s.working_register = 8'hFF; // [RULE2]
                  end
                  OPC_LONG_CALL: next_s.pc = {s.pc_high_latch, s.instr[7:0]}; // [RULE3]
                  OPC_JUMP: next_s.pc = {s.pc[15:13], s.instr[12:0]};
                  OPC_SKIP: begin
                     // the already fetched word is dropped, its slot ran as a no_operation
                     if (skip_now) next_s.pc = s.pc + 16'h0002; // [RULE8]
                     next_s.skipped = skip_now;
                  end
                  OPC_FULLONLY: next_s.illegal = !s.ctrl[CTRL_FULL]; // [RULE9]
                  default: next_s.illegal = s.illegal;
               endcase
            end
         end
         default: next_s.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s <= '0;
         s.st <= ST_IDLE;
         s.ctrl <= CTRL_RST;
         s.pc <= PC_RST;
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign exec_busy = (s.st == ST_EXEC);

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   logic fin;
   assign fin = (s.st == ST_EXEC) && tm.done;
   localparam int LIT_DELAY = Q_PER_CYCLE;

   property p_add_ovf;
      fin && cls == OPC_ADD_LIT |=> s.flags[FLAG_OVERFLOW] ==
         (($past(s.working_register[7]) == $past(s.instr[7])) &&
          (s.working_register[7] != $past(s.working_register[7])));
   endproperty
   a_add_ovf: assert property (p_add_ovf) else $error("overflow flag wrong"); // [RULE1]

   // the timer and the state machine must agree on when an instruction runs
   property p_timer_busy;
      tm.busy == exec_busy;
   endproperty
   a_timer_busy: assert property (p_timer_busy) else $error("timer and state disagree"); // [RULE7]

   property p_file_only;
      fin && cls == OPC_SETF && file_only |=> $stable(s.working_register) &&
         s.file_data == 8'hFF;
   endproperty
   a_file_only: assert property (p_file_only) else $error("file-only wrote w"); // [RULE2]

   property p_long_call;
      fin && cls == OPC_LONG_CALL |=> s.pc == {$past(s.pc_high_latch), $past(s.instr[7:0])};
   endproperty
   a_long_call: assert property (p_long_call) else $error("long call target wrong"); // [RULE3]

   property p_tblwt_int;
      fin && cls == OPC_TABLWT && s.ctrl[CTRL_TBL_INT] |-> s.evt_seen || interrupt_event;
   endproperty
   a_tblwt_int: assert property (p_tblwt_int) else $error("table write ended early"); // [RULE4]

   property p_tblwt_ext;
      fin && cls == OPC_TABLWT && !s.ctrl[CTRL_TBL_INT] |->
         s.cyc_cnt == 8'(2 * Q_PER_CYCLE - 1);
   endproperty
   a_tblwt_ext: assert property (p_tblwt_ext) else $error("table write length"); // [RULE5]

   property p_skip_len;
      fin && cls == OPC_SKIP |->
         s.cyc_cnt == (skip_now ? 8'(2 * Q_PER_CYCLE - 1) : 8'(Q_PER_CYCLE - 1));
   endproperty
   a_skip_len: assert property (p_skip_len) else $error("skip length wrong"); // [RULE6]

   property p_branch_len;
      fin && (cls == OPC_JUMP || cls == OPC_LONG_CALL || cls == OPC_BRANCH ||
              cls == OPC_TBL_READ) |->
         s.cyc_cnt == ((cls == OPC_TBL_READ && s.instr[7:0] == PC_LOW_FILE_ADDR) ?
                       8'(3 * Q_PER_CYCLE - 1) : 8'(2 * Q_PER_CYCLE - 1));
   endproperty
   a_branch_len: assert property (p_branch_len) else $error("branch length"); // [RULE7]

   property p_skip_pc;
      fin && cls == OPC_SKIP && skip_now |=> s.pc == $past(s.pc) + 16'h0002 && s.skipped;
   endproperty
   a_skip_pc: assert property (p_skip_pc) else $error("skip did not drop word"); // [RULE8]

   property p_reduced;
      fin && cls == OPC_FULLONLY && !s.ctrl[CTRL_FULL] |=> s.illegal &&
         $stable(s.working_register);
   endproperty
   a_reduced: assert property (p_reduced) else $error("reduced variant decoded op"); // [RULE9]

   property p_add_file;
      fin && cls == OPC_ADD_FILE && !s.instr[8] |=>
         s.working_register == 8'($past(s.working_register) + $past(s.file_data)) ##1 !exec_busy;
   endproperty
   a_add_file: assert property (p_add_file) else $error("add to file result"); // [RULE10]

   property p_add_lit_len;
      start && op_decode(pwdata[15:0]) == OPC_ADD_LIT |-> ##LIT_DELAY fin && s.cyc_cnt == 8'h03;
   endproperty
   a_add_lit_len: assert property (p_add_lit_len) else $error("add literal not one cycle"); // [RULE11]

   property p_add_carry;
      fin && cls == OPC_ADD_CARRY && s.instr[8] |=> s.file_data ==
         8'($past(s.working_register) + $past(s.file_data) + {7'h00, $past(s.flags[FLAG_C])});
   endproperty
   a_add_carry: assert property (p_add_carry) else $error("add with carry result"); // [RULE12]

   c_add_carry: cover property (fin && cls == OPC_ADD_CARRY);
   c_skip: cover property (fin && cls == OPC_SKIP && skip_now);
   c_tbl_read_low: cover property (fin && cls == OPC_TBL_READ && s.instr[7:0] == PC_LOW_FILE_ADDR);
   c_tblwt_int: cover property (fin && cls == OPC_TABLWT && s.ctrl[CTRL_TBL_INT]);
   c_set_file_only: cover property (fin && cls == OPC_SETF && file_only);

endmodule : cpu_exec_top

// ===== tb/cpu_exec_top_tb.sv
// self-checking bench for the add, long call and cycle timing block
`timescale 1ns/100ps
module cpu_exec_top_tb
   import cpu_exec_pkg::*;
;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic interrupt_event = 1'b0;
   logic exec_busy;
   logic [31:0] rdat;
   logic rerr;
   logic rrdy;
   int fail_count = 0;
   int compares = 0;

   cpu_exec_top i_cpu_exec_top (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .interrupt_event(interrupt_event),
      .exec_busy(exec_busy));

   initial begin
      forever #4 core_clk = ~core_clk;
   end

   // ==========================================================
   // shared tasks
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // one edge passes first so two transfers never touch psel in one time step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) fail_count++;
      rdat = prdata;
      rerr = pslverr;
      rrdy = pready;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0000_0000);
      chk(what, rdat, exp);
   endtask : rd

   // busy length in instruction cycles; irq_at raises the interrupt after that many busy clocks
   task automatic exec(input logic [15:0] ins, input int ncyc, input int irq_at);
      int n;
      n = 0;
      apb(1'b1, OFS_INSTR, {16'h0000, ins});
      for (int i = 0; i < 400; i++) begin
         @(posedge core_clk);
         if (exec_busy === 1'b1) n++;
         else if (n > 0) break;
         if (irq_at > 0 && n == irq_at) interrupt_event <= 1'b1;
      end
      interrupt_event <= 1'b0;
      chk("busy clocks", n, ncyc * Q_PER_CYCLE);
   endtask : exec

   function automatic logic [11:0] add8(input logic [7:0] a, input logic [7:0] b,
                                        input logic ci);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      add8 = {(a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
   endfunction : add8

   task automatic run_add(input logic [15:0] ins, input logic [7:0] w, input logic [7:0] f,
                          input logic ci);
      logic [11:0] r;
      logic to_file;
      to_file = (ins[15:8] == OP_ADD_LIT) ? 1'b0 : ins[8];
      r = add8(w, (ins[15:8] == OP_ADD_LIT) ? ins[7:0] : f, ci);
      wr(OFS_WORK, {24'h0000_00, w});
      wr(OFS_FILE, {24'h0000_00, f});
      wr(OFS_FLAGS, {31'h0000_0000, ci});
      exec(ins, 1, 0);
      rd(OFS_WORK, {24'h0000_00, to_file ? w : r[7:0]}, "working_register");
      rd(OFS_FILE, {24'h0000_00, to_file ? r[7:0] : f}, "file operand");
      rd(OFS_FLAGS, {28'h000_0000, r[11:8]}, "flags");
   endtask : run_add

   // ==========================================================
   // scenarios
   task automatic t_add();
      run_add(16'hB115, 8'h10, 8'h00, 1'b0);
      run_add(16'hB101, 8'h7F, 8'h00, 1'b0);
      run_add(16'h0E10, 8'h17, 8'hC2, 1'b0);
      run_add(16'h0F10, 8'h80, 8'h80, 1'b0);
      run_add(16'h1010, 8'h4D, 8'h02, 1'b1);
      run_add(16'h1110, 8'hFF, 8'h00, 1'b1);
   endtask : t_add

   task automatic t_negw();
      for (int s = 0; s < 2; s++) begin
         wr(OFS_WORK, 32'h0000_0005);
         wr(OFS_FILE, 32'h0000_0033);
         exec({OP_NEGW, s[0], 8'h10}, 1, 0);
         rd(OFS_FILE, 32'h0000_00FB, "negated file");
         rd(OFS_WORK, s[0] ? 32'h0000_0005 : 32'h0000_00FB, "w after negate");
         wr(OFS_WORK, 32'h0000_0005);
         exec({OP_SETF, s[0], 8'h10}, 1, 0);
         rd(OFS_FILE, 32'h0000_00FF, "set file");
         rd(OFS_WORK, s[0] ? 32'h0000_0005 : 32'h0000_00FF, "w after set");
      end
   endtask : t_negw

   task automatic t_long_call();
      wr(OFS_PC_LATCH, 32'h0000_0012);
      exec(16'hB734, 2, 0);
      rd(OFS_PC, 32'h0000_1234, "pc after long_call");
      exec(16'hC123, 2, 0);
      rd(OFS_PC, 32'h0000_0123, "pc after jump");
      exec(16'h0002, 2, 0);
      exec(16'hB655, 2, 0);
      rd(OFS_PC, 32'h0000_0125, "pc after returns");
   endtask : t_long_call

   task automatic t_skip();
      logic [31:0] p;
      apb(1'b0, OFS_PC, 32'h0000_0000);
      p = rdat;
      wr(OFS_FILE, 32'h0000_0000);
      exec(16'h3310, 2, 0);
      rd(OFS_PC, p + 32'h0000_0002, "pc after skip");
      rd(OFS_STAT, 32'h0000_0002, "skip taken");
      wr(OFS_FILE, 32'h0000_0005);
      exec(16'h3310, 1, 0);
      rd(OFS_PC, p + 32'h0000_0003, "pc no skip");
      exec(16'h9010, 2, 0);
      exec(16'h9910, 2, 0);
      exec(16'h9810, 1, 0);
   endtask : t_skip

   // internal write only ends on the interrupt, so the bench must raise it
   task automatic t_table();
      exec(16'hA802, 3, 0);
      exec(16'hA805, 2, 0);
      exec(16'hAC05, 2, 0);
      wr(OFS_CTRL, 32'h0000_0003);
      exec(16'hAC05, 3, 10);
      wr(OFS_CTRL, 32'h0000_0001);
   endtask : t_table

   task automatic t_reduced();
      wr(OFS_CTRL, 32'h0000_0000);
      exec(16'hBC05, 1, 0);
      rd(OFS_STAT, 32'h0000_0004, "illegal on reduced");
      wr(OFS_CTRL, 32'h0000_0001);
      exec(16'hBC05, 1, 0);
      rd(OFS_STAT, 32'h0000_0000, "legal on full");
   endtask : t_reduced

   task automatic t_bus();
      rd(OFS_CTRL, {30'h0000_0000, CTRL_RST}, "ctrl reset");
      rd(OFS_PC, {16'h0000, PC_RST}, "pc reset");
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk("unmapped error", {31'h0000_0000, rerr}, 32'h0000_0001);
      chk("unmapped data", rdat, 32'h0000_0000);
      chk("ready in access", {31'h0000_0000, rrdy}, 32'h0000_0001);
   endtask : t_bus

   // ==========================================================
   // sequence, watchdog and verdict
   task automatic end_of_test();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test

   initial begin
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_bus();
      t_add();
      t_negw();
      t_long_call();
      t_skip();
      t_table();
      t_reduced();
      end_of_test();
   end

   // the whole run needs about five hundred clocks; this allows far more
   initial begin
      #400000;
      fail_count++;
      end_of_test();
   end
endmodule : cpu_exec_top_tb
